// file: core/tpo_panel_ctrl.sv
// Register file, timing generator and pixel output stage for a TFT panel.
`timescale 1ns/1ps
module tpo_panel_ctrl
	import tpo_pkg::*;
(
	input  wire logic           pclk,
	input  wire logic           presetn,
	input  wire logic           psel,
	input  wire logic           penable,
	input  wire logic           pwrite,
	input  wire logic [11:0]    paddr,
	input  wire logic [31:0]    pwdata,
	output logic      [31:0]    prdata,
	output logic                pready,
	output logic                pslverr,
	input  wire logic           link_clk,
	input  wire logic           power_save,
	input  wire tpo_rgb_t       main_pixel,
	input  wire tpo_rgb_t       first_overlay_pixel,
	input  wire logic           first_overlay_hit,
	input  wire tpo_rgb_t       second_overlay_pixel,
	input  wire logic           second_overlay_hit,
	output tpo_panel_t          panel,
	output logic [X_W-1:0]      pixel_x,
	output logic [Y_W-1:0]      scan_line,
	output logic                overlay_param_sel,
	output tpo_bpp_t            main_bpp,
	output tpo_bpp_t            first_overlay_bpp,
	output tpo_bpp_t            second_overlay_bpp,
	output logic                cursor_enable,
	output logic [7:0]          panel_pin_alt
);

	logic [7:0]  panel_pin_function_select;
	logic [7:0]  window_control;
	logic [7:0]  overlay_color_depth;
	logic [7:0]  display_configuration;
	logic [7:0]  panel_polarity_idle;
	logic [7:0]  status_word;
	logic [7:0]  read_mux;
	logic        frame_toggle;

	// Bus decode; the register index sits above the byte lane bits.
	wire  [7:0]  reg_idx   = paddr[9:2];
	wire         in_range  = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
	wire         hit_pin   = in_range && (reg_idx == PIN_FUNC_IDX);
	wire         hit_win   = in_range && (reg_idx == WIN_CTRL_IDX);
	wire         hit_ovl   = in_range && (reg_idx == OVL_DEPTH_IDX);
	wire         hit_disp  = in_range && (reg_idx == DISP_CFG_IDX);
	wire         hit_pol   = in_range && (reg_idx == POL_IDLE_IDX);
	wire         hit_stat  = in_range && (reg_idx == STATUS_IDX);
	wire         hit_any   = hit_pin | hit_win | hit_ovl | hit_disp | hit_pol | hit_stat;
	wire         setup     = psel && !penable;
	wire         wr_access = psel && penable && pwrite;

	// Zero wait states: read data is captured during setup.
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !hit_any;

	assign read_mux = hit_pin  ? panel_pin_function_select :
	                  hit_win  ? window_control :
	                  hit_ovl  ? overlay_color_depth :
	                  hit_disp ? display_configuration :
	                  hit_pol  ? panel_polarity_idle :
	                  hit_stat ? status_word : 8'h00;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (setup && !pwrite) begin
			prdata <= {24'h000000, read_mux};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			panel_pin_function_select <= PIN_FUNC_RST;
			window_control            <= WIN_CTRL_RST;
			overlay_color_depth       <= OVL_DEPTH_RST;
			display_configuration     <= DISP_CFG_RST;
			panel_polarity_idle       <= POL_IDLE_RST;
		end else if (wr_access) begin
			if (hit_pin)
				panel_pin_function_select <= pwdata[7:0];
			if (hit_win)
				window_control <= pwdata[7:0] & WIN_CTRL_MASK;
			if (hit_ovl)
				overlay_color_depth <= pwdata[7:0] & OVL_DEPTH_MASK;
			if (hit_disp)
				display_configuration <= pwdata[7:0];
			if (hit_pol)
				panel_polarity_idle <= pwdata[7:0];
		end
	end

	// Depth decode: the upper bit set means 24bpp whatever the lower bit.
	function automatic tpo_bpp_t decode_bpp(input logic [1:0] code);
		tpo_bpp_t res;
		res = code[1] ? TPO_BPP24 : (code[0] ? TPO_BPP16 : TPO_BPP8);
		return res;
	endfunction : decode_bpp

	wire [1:0] main_code   = window_control[WC_DEPTH_HI -: 2];
	wire [1:0] first_code  = overlay_color_depth[OD_FIRST_HI -: 2];
	wire [1:0] second_code = overlay_color_depth[OD_SECOND_HI -: 2];
	assign main_bpp           = decode_bpp(main_code);
	assign first_overlay_bpp  = decode_bpp(first_code);
	assign second_overlay_bpp = decode_bpp(second_code);
	assign overlay_param_sel  = window_control[WC_OVL_SEL];

	// Pins shared with other functions are only released below 24bpp.
	assign panel_pin_alt = (main_bpp == TPO_BPP24) ? 8'h00 : panel_pin_function_select;

	wire scan_up    = display_configuration[DC_SCAN_DIR];
	wire ovl_allow  = !scan_up;
	wire first_on   = window_control[WC_FIRST_EN] && ovl_allow && first_overlay_hit;
	wire second_on  = window_control[WC_SECOND_EN] && ovl_allow && second_overlay_hit;
	assign cursor_enable = ovl_allow;

	// Link clock crossing; the first stage feeds only the second, the second and third feed the logic.
	logic lk_meta;
	logic lk_sync;
	logic lk_prev;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lk_meta <= 1'b0;
			lk_sync <= 1'b0;
			lk_prev <= 1'b0;
		end else begin
			lk_meta <= link_clk;
			lk_sync <= lk_meta;
			lk_prev <= lk_sync;
		end
	end

	wire lk_rise  = lk_sync && !lk_prev;
	wire lk_fall  = !lk_sync && lk_prev;
	wire clk_inv  = display_configuration[DC_CLK_INV];
	// Launch on the edge opposite the one the panel samples on.
	wire launch   = clk_inv ? lk_rise : lk_fall;
	wire running  = display_configuration[DC_DISP_ON] && !power_save;

	// Horizontal timing state machine.
	tpo_hstate_t      hstate;
	tpo_hstate_t      next_hstate;
	logic [X_W-1:0]   hcnt;
	logic [X_W-1:0]   next_hcnt;
	logic [Y_W-1:0]   vcnt;
	logic             line_end;

	always_comb begin
		next_hstate = hstate;
		next_hcnt   = hcnt + 6'h01;
		line_end    = 1'b0;
		case (hstate)
			H_ACTIVE: begin
				if (hcnt == H_ACT) begin
					next_hstate = H_FRONT;
					next_hcnt   = 6'h00;
				end
			end
			H_FRONT: begin
				if (hcnt == H_FP) begin
					next_hstate = H_SYNC;
					next_hcnt   = 6'h00;
				end
			end
			H_SYNC: begin
				if (hcnt == H_SW) begin
					next_hstate = H_BACK;
					next_hcnt   = 6'h00;
				end
			end
			H_BACK: begin
				if (hcnt == H_BP) begin
					next_hstate = H_ACTIVE;
					next_hcnt   = 6'h00;
					line_end    = 1'b1;
				end
			end
			default: begin
				next_hstate = H_ACTIVE;
				next_hcnt   = 6'h00;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hstate <= H_ACTIVE;
			hcnt   <= 6'h00;
		end else if (!running) begin
			hstate <= H_ACTIVE;
			hcnt   <= 6'h00;
		end else if (launch) begin
			hstate <= next_hstate;
			hcnt   <= next_hcnt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vcnt         <= 4'h0;
			frame_toggle <= 1'b0;
		end else if (!running) begin
			vcnt <= 4'h0;
		end else if (launch && line_end) begin
			if (vcnt == V_LAST) begin
				vcnt         <= 4'h0;
				frame_toggle <= !frame_toggle;
			end else begin
				vcnt <= vcnt + 4'h1;
			end
		end
	end

	wire v_active  = vcnt <= V_ACT;
	wire v_sync    = (vcnt >= V_SYNC_FIRST) && (vcnt <= V_SYNC_LAST);
	wire h_active  = hstate == H_ACTIVE;
	wire h_sync    = hstate == H_SYNC;
	wire active    = h_active && v_active;

	// Bottom-up scan walks the lines in reverse for the fetch side.
	wire [Y_W-1:0] line_idx = scan_up ? (V_ACT - vcnt) : vcnt;

	// Composition: first overlay wins over second, second over main.
	wire tpo_rgb_t layered = first_on  ? first_overlay_pixel :
	                         second_on ? second_overlay_pixel : main_pixel;

	// Eight vertical bars cycling through black, the primary and secondary colours and white.
	wire [2:0] bar_idx = hcnt[X_W-1 -: 3];
	wire tpo_rgb_t bar_pixel = '{r: {8{bar_idx[2]}}, g: {8{bar_idx[1]}}, b: {8{bar_idx[0]}}};
	wire tpo_rgb_t src = display_configuration[DC_COLOR_BAR] ? bar_pixel : layered;

	wire [9:0] grey_sum = {2'h0, src.r} + {1'h0, src.g, 1'h0} + {2'h0, src.b};
	wire [7:0] grey     = grey_sum[9:2];
	wire [23:0] idle_fill = {24{panel_polarity_idle[PI_DATA_IDLE]}};
	logic [23:0] ordered;

	// With code 111b software is expected to have set the data idle level.
	always_comb begin
		case (display_configuration[DC_ORDER_HI -: 3])
			3'h0: ordered = {src.r, src.g, src.b};
			3'h1: ordered = {src.r, src.b, src.g};
			3'h2: ordered = {src.g, src.r, src.b};
			3'h3: ordered = {src.g, src.b, src.r};
			3'h4: ordered = {src.b, src.r, src.g};
			3'h5: ordered = {src.b, src.g, src.r};
			3'h6: ordered = {grey, grey, grey};
			default: ordered = idle_fill;
		endcase
	end

	wire de_mode  = window_control[WC_DE_MODE];
	wire hs_level = de_mode ? panel_polarity_idle[PI_HS_IDLE]
	                        : !(h_sync ^ panel_polarity_idle[PI_HS_POL]);
	wire vs_level = de_mode ? panel_polarity_idle[PI_VS_IDLE]
	                        : !(v_sync ^ panel_polarity_idle[PI_VS_POL]);
	wire de_level = active ^ panel_polarity_idle[PI_DE_POL];

	// The outgoing clock lags one more cycle so data changes near its far edge.
	tpo_panel_t next_panel;
	always_comb begin
		if (running) begin
			next_panel.pclk       = lk_prev;
			next_panel.hsync      = hs_level;
			next_panel.vsync      = vs_level;
			next_panel.data_valid = de_level;
			next_panel.pixel_bus  = active ? ordered : idle_fill;
		end else begin
			next_panel.pclk       = panel_polarity_idle[PI_CLK_IDLE];
			next_panel.hsync      = panel_polarity_idle[PI_HS_IDLE];
			next_panel.vsync      = panel_polarity_idle[PI_VS_IDLE];
			next_panel.data_valid = panel_polarity_idle[PI_DE_IDLE];
			next_panel.pixel_bus  = idle_fill;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			panel.pclk       <= 1'b0;
			panel.hsync      <= 1'b1;
			panel.vsync      <= 1'b1;
			panel.data_valid <= 1'b0;
			panel.pixel_bus  <= 24'h000000;
		end else begin
			panel.pclk <= next_panel.pclk;
			if (launch || !running) begin
				panel.hsync      <= next_panel.hsync;
				panel.vsync      <= next_panel.vsync;
				panel.data_valid <= next_panel.data_valid;
				panel.pixel_bus  <= next_panel.pixel_bus;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pixel_x   <= 6'h00;
			scan_line <= 4'h0;
		end else begin
			pixel_x   <= hcnt;
			scan_line <= line_idx;
		end
	end

	assign status_word = {4'h0, frame_toggle, v_active, h_active, running};

endmodule : tpo_panel_ctrl

// file: core/tpo_pkg.sv
// Constants, types and register map of the TFT panel output controller.
package tpo_pkg;

	localparam logic [7:0] PIN_FUNC_IDX  = 8'h0F;
	localparam logic [7:0] WIN_CTRL_IDX  = 8'h10;
	localparam logic [7:0] OVL_DEPTH_IDX = 8'h11;
	localparam logic [7:0] DISP_CFG_IDX  = 8'h12;
	localparam logic [7:0] POL_IDLE_IDX  = 8'h13;
	localparam logic [7:0] STATUS_IDX    = 8'h30;

	localparam logic [7:0] PIN_FUNC_RST  = 8'h00;
	localparam logic [7:0] WIN_CTRL_RST  = 8'h04;
	localparam logic [7:0] OVL_DEPTH_RST = 8'h05;
	localparam logic [7:0] DISP_CFG_RST  = 8'h00;
	localparam logic [7:0] POL_IDLE_RST  = 8'h03;
	localparam logic [7:0] WIN_CTRL_MASK = 8'hDF;
	localparam logic [7:0] OVL_DEPTH_MASK = 8'h0F;

	localparam int WC_FIRST_EN   = 7;
	localparam int WC_SECOND_EN  = 6;
	localparam int WC_OVL_SEL    = 4;
	localparam int WC_DEPTH_HI   = 3;
	localparam int WC_DE_MODE    = 0;
	localparam int OD_FIRST_HI   = 3;
	localparam int OD_SECOND_HI  = 1;
	localparam int DC_CLK_INV    = 7;
	localparam int DC_DISP_ON    = 6;
	localparam int DC_COLOR_BAR  = 5;
	localparam int DC_SCAN_DIR   = 3;
	localparam int DC_ORDER_HI   = 2;
	localparam int PI_HS_POL     = 7;
	localparam int PI_VS_POL     = 6;
	localparam int PI_DE_POL     = 5;
	localparam int PI_DE_IDLE    = 4;
	localparam int PI_CLK_IDLE   = 3;
	localparam int PI_DATA_IDLE  = 2;
	localparam int PI_HS_IDLE    = 1;
	localparam int PI_VS_IDLE    = 0;

	localparam int X_W = 6;
	localparam int Y_W = 4;
	localparam logic [X_W-1:0] H_ACT = 6'h3F;
	localparam logic [X_W-1:0] H_FP  = 6'h03;
	localparam logic [X_W-1:0] H_SW  = 6'h03;
	localparam logic [X_W-1:0] H_BP  = 6'h03;
	localparam logic [Y_W-1:0] V_ACT = 4'hB;
	localparam logic [Y_W-1:0] V_SYNC_FIRST = 4'hC;
	localparam logic [Y_W-1:0] V_SYNC_LAST  = 4'hD;
	localparam logic [Y_W-1:0] V_LAST       = 4'hE;

	typedef enum logic [1:0] {
		TPO_BPP8  = 2'h0,
		TPO_BPP16 = 2'h1,
		TPO_BPP24 = 2'h2
	} tpo_bpp_t;

	typedef enum logic [3:0] {
		H_ACTIVE = 4'h1,
		H_FRONT  = 4'h2,
		H_SYNC   = 4'h4,
		H_BACK   = 4'h8
	} tpo_hstate_t;

	typedef struct packed {
		logic [7:0] r;
		logic [7:0] g;
		logic [7:0] b;
	} tpo_rgb_t;

	typedef struct packed {
		logic        pclk;
		logic        hsync;
		logic        vsync;
		logic        data_valid;
		logic [23:0] pixel_bus;
	} tpo_panel_t;

endpackage : tpo_pkg

// file: sim/tb_top.sv
// Self-checking bench for the panel output controller.
`timescale 1ns/1ps
module tb_top;
	import tpo_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, link_clk, power_save, fall, e;
	logic first_overlay_hit, second_overlay_hit, overlay_param_sel;
	logic cursor_enable, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [7:0] panel_pin_alt;
	logic [23:0] got;
	tpo_rgb_t main_pixel, first_overlay_pixel, second_overlay_pixel;
	tpo_panel_t panel;
	tpo_bpp_t main_bpp, first_overlay_bpp, second_overlay_bpp;
	int cnt, n_errors = 0, total_checks = 0;

	tpo_panel_ctrl u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .link_clk, .power_save, .main_pixel, .first_overlay_pixel,
		.first_overlay_hit, .second_overlay_pixel, .second_overlay_hit, .panel, .pixel_x(),
		.scan_line(), .overlay_param_sel, .main_bpp, .first_overlay_bpp, .second_overlay_bpp,
		.cursor_enable, .panel_pin_alt);
	tpo_panel_model u_panel (.panel, .fall, .got, .cnt);

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		total_checks++;
		if (g !== x) begin
			n_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, g, x);
		end
	endtask : chk

	task automatic hang;
		chk(0, 1);
		print_verdict();
	endtask : hang

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 64) hang();
	endtask : apb

	// Waits for three fresh panel captures so no pixel of the old setting is judged.
	task automatic samp(input logic [23:0] x);
		int n, c0;
		n = 0;
		c0 = cnt;
		while (cnt < c0 + 3 && n < 12000) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 12000) hang();
		chk(got, x);
	endtask : samp

	function automatic logic [1:0] bp(input logic [1:0] c);
		return c[1] ? 2'h2 : c;
	endfunction : bp

	function automatic logic [27:0] idle(input logic [7:0] v);
		return {v[3], v[1], v[0], v[4], {24{v[2]}}};
	endfunction : idle

	// Main pixel is r 11, g 22, b 33; grey is (r + 2g + b) / 4.
	function automatic logic [23:0] ord(input logic [2:0] c);
		case (c)
			3'h0: return 24'h112233;
			3'h1: return 24'h113322;
			3'h2: return 24'h221133;
			3'h3: return 24'h223311;
			3'h4: return 24'h331122;
			3'h5: return 24'h332211;
			3'h6: return 24'h222222;
			default: return 24'h000000;
		endcase
	endfunction : ord

	task automatic t_regs;
		logic [11:0] a [5] = '{12'h03C, 12'h040, 12'h044, 12'h048, 12'h04C};
		logic [7:0] r [5] = '{8'h00, 8'h04, 8'h05, 8'h00, 8'h03};
		for (int i = 0; i < 5; i++) begin
			apb(0, a[i], 0);
			chk(q, r[i]);
		end
		apb(1, 12'h03C, 32'hA5);
		apb(1, 12'h040, 32'hFF);
		apb(0, 12'h040, 0);
		chk(q, 32'hDF);
		chk(overlay_param_sel, 1);
		chk(panel_pin_alt, 0);
		apb(1, 12'h044, 32'hFF);
		apb(0, 12'h044, 0);
		chk(q, 32'h0F);
		apb(1, 12'h040, 32'h04);
		@(posedge pclk);
		chk(panel_pin_alt, 8'hA5);
		apb(1, 12'h0C4, 32'hFF);
		chk(e, 1);
		apb(0, 12'h0C4, 0);
		chk(q, 0);
		$display("regs done");
	endtask : t_regs

	task automatic t_bpp;
		for (int d = 0; d < 4; d++) begin
			apb(1, 12'h040, d << 2);
			apb(1, 12'h044, {d[1:0], ~d[1:0]});
			@(posedge pclk);
			chk(main_bpp, bp(d[1:0]));
			chk(first_overlay_bpp, bp(d[1:0]));
			chk(second_overlay_bpp, bp(~d[1:0]));
		end
		apb(1, 12'h040, 32'h04);
		$display("bpp done");
	endtask : t_bpp

	task automatic t_idle;
		logic [7:0] v [2] = '{8'h03, 8'h1C};
		for (int i = 0; i < 2; i++) begin
			apb(1, 12'h04C, v[i]);
			repeat (3) @(posedge pclk);
			chk(panel, idle(v[i]));
		end
		apb(1, 12'h048, 32'h40);
		power_save <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(panel, idle(8'h1C));
		power_save <= 1'b0;
		$display("idle done");
	endtask : t_idle

	task automatic t_order;
		apb(1, 12'h04C, 32'h03);
		for (int c = 0; c < 8; c++) begin
			apb(1, 12'h048, 32'h40 | c);
			samp(ord(c[2:0]));
		end
		apb(1, 12'h048, 32'hC0);
		fall <= 1'b1;
		samp(24'h112233);
		fall <= 1'b0;
		$display("order done");
	endtask : t_order

	// Colour bars: every byte of a captured pixel is all zeros or all ones.
	task automatic t_bar;
		int n, c0;
		apb(1, 12'h048, 32'h60);
		c0 = cnt;
		for (n = 0; n < 12000 && cnt < c0 + 3; n++) @(posedge pclk);
		if (n >= 12000) hang();
		chk({got[23:16] == {8{got[23]}}, got[15:8] == {8{got[15]}}, got[7:0] == {8{got[7]}}},
			3'h7);
		apb(0, 12'h0C0, 0);
		chk(q[0], 1'b1);
		apb(1, 12'h048, 32'h40);
		$display("bar done");
	endtask : t_bar

	task automatic t_ovl;
		logic [7:0] w [5] = '{8'hC4, 8'h44, 8'h84, 8'h04, 8'hC4};
		logic [23:0] x [5] = '{24'hAAAAAA, 24'h555555, 24'hAAAAAA, 24'h112233, 24'h112233};
		first_overlay_hit <= 1'b1;
		second_overlay_hit <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			apb(1, 12'h040, w[i]);
			apb(1, 12'h048, i == 4 ? 32'h48 : 32'h40);
			samp(x[i]);
		end
		chk(cursor_enable, 0);
		$display("overlay done");
	endtask : t_ovl

	// Counts cycles at the active sync level; a line holds a short sync pulse.
	task automatic t_sync;
		logic [7:0] w [3] = '{8'h04, 8'h05, 8'h04};
		logic [7:0] v [3] = '{8'h03, 8'h03, 8'h83};
		int k;
		for (int i = 0; i < 3; i++) begin
			apb(1, 12'h040, w[i]);
			apb(1, 12'h04C, v[i]);
			k = 0;
			repeat (3000) begin
				@(posedge pclk);
				k += (panel.hsync === v[i][7]);
			end
			chk(k > 0 && k < 600, i != 1);
		end
		$display("sync done");
	endtask : t_sync

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	initial begin
		link_clk = 1'b0;
		#7;
		forever #62.5 link_clk = ~link_clk;
	end

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, power_save, fall} = '0;
		{first_overlay_hit, second_overlay_hit} = '0;
		paddr = '0;
		pwdata = '0;
		main_pixel = 24'h112233;
		first_overlay_pixel = 24'hAAAAAA;
		second_overlay_pixel = 24'h555555;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_bpp();
		t_idle();
		t_order();
		t_bar();
		t_ovl();
		t_sync();
		print_verdict();
	end
endmodule : tb_top

// file: sim/tpo_panel_model.sv
// Panel model that takes pixel data on the chosen pixel clock edge.
`timescale 1ns/1ps
module tpo_panel_model
	import tpo_pkg::*;
(
	input wire tpo_panel_t	panel,
	input wire logic		fall,
	output logic [23:0]		got,
	output int				cnt
);
	initial cnt = 0;
	// Rising edge when fall is low, falling edge when fall is high.
	always @(panel.pclk) if (panel.pclk === !fall && panel.data_valid === 1'b1) begin
		got <= panel.pixel_bus;
		cnt <= cnt + 1;
	end
endmodule : tpo_panel_model

// file: sim/tpo_panel_props.sv
// Checker for register decode, depth selection and idle hold of the panel controller.
`timescale 1ns/1ps
module tpo_panel_props
	import tpo_pkg::*;
(
	input wire logic		pclk,
	input wire logic		presetn,
	input wire logic		psel,
	input wire logic		penable,
	input wire logic		pwrite,
	input wire logic [11:0]	paddr,
	input wire logic [31:0]	pwdata,
	input wire logic		pslverr,
	input wire logic		power_save,
	input wire tpo_panel_t	panel,
	input wire logic		overlay_param_sel,
	input wire tpo_bpp_t	main_bpp,
	input wire tpo_bpp_t	first_overlay_bpp,
	input wire tpo_bpp_t	second_overlay_bpp,
	input wire logic		cursor_enable,
	input wire logic [7:0]	panel_pin_alt
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	function automatic tpo_bpp_t dec(input logic [1:0] c);
		return c[1] ? TPO_BPP24 : tpo_bpp_t'(c);
	endfunction : dec
	sequence wr_win; psel && penable && pwrite && paddr == 12'h040; endsequence
	sequence wr_ovl; psel && penable && pwrite && paddr == 12'h044; endsequence
	sequence wr_cfg; psel && penable && pwrite && paddr == 12'h048; endsequence
	// Three quiet cycles let the idle levels settle before stability is demanded.
	sequence quiet; (power_save && !psel)[*3]; endsequence
	sel_route_a: assert property (wr_win |=> overlay_param_sel == $past(pwdata[4]))
		else $error("overlay select does not follow write");
	main_depth_a: assert property (wr_win |=> main_bpp == dec($past(pwdata[3:2])))
		else $error("main depth decode wrong");
	first_depth_a: assert property (wr_ovl |=> first_overlay_bpp == dec($past(pwdata[3:2])))
		else $error("first overlay depth wrong");
	second_depth_a: assert property (wr_ovl |=> second_overlay_bpp == dec($past(pwdata[1:0])))
		else $error("second overlay depth wrong");
	scan_cursor_a: assert property (wr_cfg |=> cursor_enable == !$past(pwdata[3]))
		else $error("cursor not suppressed by scan direction");
	pin_release_a: assert property (main_bpp == TPO_BPP24 |-> panel_pin_alt == 8'h00)
		else $error("pins released in full depth mode");
	idle_hold_a: assert property (quiet |-> $stable(panel))
		else $error("panel moves in power saving");
	map_ok_a: assert property (psel && penable && paddr == 12'h04C |-> !pslverr)
		else $error("polarity register refused");
endmodule : tpo_panel_props

bind tpo_panel_ctrl tpo_panel_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pslverr, .power_save, .panel, .overlay_param_sel, .main_bpp, .first_overlay_bpp,
	.second_overlay_bpp, .cursor_enable, .panel_pin_alt);
